// File: rtl/grs_device.sv
`include "grs_params.svh"
module grs_device (
  input  wire logic mclk_i,
  input  wire logic reset_i,
  grs_if.dev        lnk,
  output logic      integrating_o,
  output logic      resuming_o
);
  grs_pkg::grs_state_e state_reg, state_next;
  logic [11:0] col_reg, col_next, row_reg, row_next;
  logic [10:0] pre_reg;
  logic [23:0] phase_reg, tail_reg;
  logic [16:0] res_reg;
  logic [15:0] coarse_sh_reg, icnt_reg, strb_cnt_reg;
  logic [11:0] tmo_reg;
  logic [2:0]  dly_reg;
  logic        trig_prev_reg, vd_prev_reg, halt_reg, res_on_reg;
  logic        bulb_reg, strb_en_reg, sglob_reg;
  logic        shut_reg, strb_reg, lv_reg, fv_reg;
  logic [15:0] pix_reg;

  ////////////////////////////////////////////////////////////////
  wire trig_level = lnk.cfg.sw_trig |
                    (lnk.cfg.gpi_trig_en & lnk.general_input_pin);
  wire trig_rise  = trig_level & ~trig_prev_reg;
  wire vd_rise    = lnk.vertical_sync_in & ~vd_prev_reg;
  wire in_roll    = state_reg == grs_pkg::ST_ROLL;
  wire running    = lnk.cfg.stream | ~in_roll | res_on_reg;
  // no retrigger while the shutter is still closed
  wire accept     = trig_rise & in_roll & ~res_on_reg & ~shut_reg &
                    lnk.cfg.stream;
  wire slave      = lnk.cfg.per_frame_sync_enable |
                    lnk.cfg.sync_triggered_global_enable;
  wire col_last   = col_reg == `GRS_LINE_LAST;
  wire row_last   = row_reg == `GRS_FRAME_LAST;
  wire frame_last = col_last & row_last;
  wire read_last  = col_last & (row_reg == `GRS_OUT_LAST);
  wire in_frame   = row_reg < `GRS_OUT_ROWS;
  wire in_cols    = col_reg < `GRS_ACT_COLS;
  wire [10:0] scale_max = lnk.cfg.prescale == 2'h0 ? `GRS_SCALE0 :
                          lnk.cfg.prescale == 2'h1 ? `GRS_SCALE1 :
                          lnk.cfg.prescale == 2'h2 ? `GRS_SCALE2 :
                          `GRS_SCALE3;
  wire tick       = pre_reg == scale_max;
  wire timed      = state_reg == grs_pkg::ST_RESET ||
                    state_reg == grs_pkg::ST_INTEG ||
                    state_reg == grs_pkg::ST_TAIL;
  wire rst_done   = phase_reg == {8'h00, lnk.cfg.rst_end};
  wire shut_hit   = phase_reg == lnk.cfg.shut_start;
  wire read_hit   = phase_reg == lnk.cfg.read_start;
  wire [23:0] tail_load = lnk.cfg.read_start - lnk.cfg.shut_start;
  wire tmo_hit    = lnk.cfg.sync_wait_timeout_enable &
                    (tmo_reg == `GRS_SYNC_TMO);
  wire [16:0] res_target = {1'b0, coarse_sh_reg} + `GRS_RESUME_BASE;
  wire res_line   = res_on_reg & col_last;
  wire res_done   = res_line & (res_reg + 17'h0_0001 == res_target);
  wire roll_cnt   = in_roll & running & ~halt_reg & ~res_on_reg;
  wire cnt_en     = roll_cnt || state_reg == grs_pkg::ST_ROWEND ||
                    state_reg == grs_pkg::ST_FRWAIT ||
                    state_reg == grs_pkg::ST_READ || res_on_reg;
  wire enter_read = state_reg != grs_pkg::ST_READ &&
                    state_next == grs_pkg::ST_READ;
  wire enter_rst  = state_reg != grs_pkg::ST_RESET &&
                    state_next == grs_pkg::ST_RESET;
  wire read_end   = state_reg == grs_pkg::ST_READ & read_last;
  wire halt_set   = roll_cnt & frame_last &
                    lnk.cfg.per_frame_sync_enable;
  wire strb_start = state_reg == grs_pkg::ST_INTEG & strb_en_reg &
                    icnt_reg == `GRS_STROBE_DLY &
                    lnk.cfg.strobe_len != 16'h0000;

  ////////////////////////////////////////////////////////////////
  always_comb begin
    state_next = state_reg;
    case (state_reg)
      grs_pkg::ST_ROLL: begin
        if (accept)
          state_next = slave ? grs_pkg::ST_FRWAIT
                             : grs_pkg::ST_ROWEND;
      end
      grs_pkg::ST_ROWEND: begin
        if (!in_frame || dly_reg == `GRS_ROWEND_LAST)
          state_next = grs_pkg::ST_RESET;
      end
      grs_pkg::ST_FRWAIT: begin
        if (frame_last)
          state_next = lnk.cfg.sync_triggered_global_enable ?
                       grs_pkg::ST_VDWAIT : grs_pkg::ST_RESET;
      end
      grs_pkg::ST_VDWAIT: begin
        if (vd_rise)
          state_next = grs_pkg::ST_RESET;
      end
      grs_pkg::ST_RESET: begin
        if (rst_done)
          state_next = grs_pkg::ST_INTEG;
      end
      grs_pkg::ST_INTEG: begin
        if (sglob_reg) begin
          if (vd_rise)
            state_next = grs_pkg::ST_READ;
        end else if (bulb_reg) begin
          if (!trig_level && phase_reg >= lnk.cfg.shut_start)
            state_next = grs_pkg::ST_TAIL;
        end else if (read_hit) begin
          state_next = grs_pkg::ST_READ;
        end
      end
      grs_pkg::ST_TAIL: begin
        if (tail_reg == 24'h00_0000)
          state_next = grs_pkg::ST_READ;
      end
      grs_pkg::ST_READ: begin
        if (read_last)
          state_next = grs_pkg::ST_ROLL;
      end
      default: state_next = grs_pkg::ST_ROLL;
    endcase
  end

  ////////////////////////////////////////////////////////////////
  always_comb begin
    col_next = col_reg;
    row_next = row_reg;
    if (enter_read || (in_roll && !running) || res_done) begin
      col_next = 12'h000;
      row_next = 12'h000;
    end else if (cnt_en) begin
      col_next = col_last ? 12'h000 : col_reg + 12'h001;
      if (col_last)
        row_next = row_last ? 12'h000 : row_reg + 12'h001;
    end
  end

  ////////////////////////////////////////////////////////////////
  always_ff @(posedge mclk_i) begin
    if (reset_i) begin
      state_reg     <= grs_pkg::ST_ROLL;
      col_reg       <= 12'h000;
      row_reg       <= 12'h000;
      trig_prev_reg <= 1'b0;
      vd_prev_reg   <= 1'b0;
    end else begin
      state_reg     <= state_next;
      col_reg       <= col_next;
      row_reg       <= row_next;
      trig_prev_reg <= trig_level;
      vd_prev_reg   <= lnk.vertical_sync_in;
    end
  end

  // counters stop waiting on a missing sync edge after GRS_SYNC_TMO clocks once timeout is on
  always_ff @(posedge mclk_i) begin
    if (reset_i || !halt_reg)
      tmo_reg <= 12'h000;
    else
      tmo_reg <= tmo_reg + 12'h001;
    if (reset_i || vd_rise || tmo_hit)
      halt_reg <= 1'b0;
    else if (halt_set)
      halt_reg <= 1'b1;
  end

  always_ff @(posedge mclk_i) begin
    if (reset_i || state_reg != grs_pkg::ST_ROWEND || !in_cols)
      dly_reg <= (reset_i || state_reg != grs_pkg::ST_ROWEND) ?
                 3'h0 : dly_reg + 3'h1;
    if (reset_i || enter_rst || tick || !timed)
      pre_reg <= 11'h000;
    else
      pre_reg <= pre_reg + 11'h001;
    if (reset_i || enter_rst)
      phase_reg <= 24'h00_0000;
    else if (timed && tick)
      phase_reg <= phase_reg + 24'h00_0001;
    if (reset_i || state_reg != grs_pkg::ST_TAIL)
      tail_reg <= tail_load;
    else if (tick)
      tail_reg <= tail_reg - 24'h00_0001;
  end

  always_ff @(posedge mclk_i) begin
    if (reset_i) begin
      bulb_reg    <= 1'b0;
      strb_en_reg <= 1'b0;
      sglob_reg   <= 1'b0;
    end else if (accept) begin
      bulb_reg    <= lnk.cfg.bulb;
      strb_en_reg <= lnk.cfg.strobe_en;
      sglob_reg   <= lnk.cfg.sync_triggered_global_enable;
    end
  end

  // sensor shadow: rolling frame start, or just before readout
  always_ff @(posedge mclk_i) begin
    if (reset_i)
      coarse_sh_reg <= 16'h0000;
    else if (enter_read || (roll_cnt && col_reg == 12'h000 &&
                            row_reg == 12'h000))
      coarse_sh_reg <= lnk.cfg.coarse_exp;
  end

  always_ff @(posedge mclk_i) begin
    if (reset_i || read_end)
      res_reg <= 17'h0_0000;
    else if (res_line)
      res_reg <= res_reg + 17'h0_0001;
    if (reset_i || res_done)
      res_on_reg <= 1'b0;
    else if (read_end)
      res_on_reg <= 1'b1;
    if (reset_i || (res_line && res_reg + 17'h0_0001 ==
                    `GRS_SHUT_LINES))
      shut_reg <= 1'b0;
    else if (timed && shut_hit)
      shut_reg <= 1'b1;
  end

  always_ff @(posedge mclk_i) begin
    if (reset_i || state_reg != grs_pkg::ST_INTEG)
      icnt_reg <= 16'h0000;
    else if (icnt_reg != 16'hffff)
      icnt_reg <= icnt_reg + 16'h0001;
    if (reset_i) begin
      strb_reg     <= 1'b0;
      strb_cnt_reg <= 16'h0000;
    end else if (strb_start) begin
      strb_reg     <= 1'b1;
      strb_cnt_reg <= lnk.cfg.strobe_len;
    end else if (strb_reg) begin
      strb_reg     <= strb_cnt_reg != 16'h0001;
      strb_cnt_reg <= strb_cnt_reg - 16'h0001;
    end
  end

  ////////////////////////////////////////////////////////////////
  wire vid = (roll_cnt || state_reg == grs_pkg::ST_ROWEND ||
              state_reg == grs_pkg::ST_FRWAIT ||
              state_reg == grs_pkg::ST_READ) && in_frame;
  wire fv_next = vid || (state_reg == grs_pkg::ST_ROWEND &&
                         state_next == grs_pkg::ST_ROWEND);
  wire lv_next = vid && in_cols &&
                 !(state_reg == grs_pkg::ST_ROWEND && dly_reg != 3'h0);
  // embedded rows carry the programmed value, not the real exposure
  wire [15:0] pix_next = row_reg < `GRS_EMB_ROWS ?
                         coarse_sh_reg : {4'h0, col_reg};

  always_ff @(posedge mclk_i) begin
    if (reset_i) begin
      fv_reg  <= 1'b0;
      lv_reg  <= 1'b0;
      pix_reg <= 16'h0000;
    end else begin
      fv_reg  <= fv_next;
      lv_reg  <= lv_next;
      pix_reg <= lv_next ? pix_next : 16'h0000;
    end
  end

  assign lnk.frame_valid_flag = fv_reg;
  assign lnk.line_valid_flag  = lv_reg;
  assign lnk.pix_data         = pix_reg;
  assign lnk.shutter          = shut_reg;
  assign lnk.strobe           = strb_reg;
  assign lnk.busy             = ~in_roll | res_on_reg;
  assign lnk.standby          = ~running;
  assign integrating_o = state_reg == grs_pkg::ST_INTEG ||
                         state_reg == grs_pkg::ST_TAIL ||
                         (res_on_reg &&
                          res_reg >= `GRS_INTEG_LINES);
  assign resuming_o    = res_on_reg;
endmodule

// File: rtl/grs_host.sv
`include "grs_params.svh"
module grs_host (
  input  wire logic        mclk_i,
  input  wire logic        reset_i,
  grs_if.hst               lnk,
  input  wire logic [3:0]  addr_i,
  input  wire logic [31:0] wdata_i,
  input  wire logic        wr_i,
  input  wire logic        rd_i,
  output logic [31:0]      rdata_o
);
  logic [15:0] ctrl_reg, rst_reg, shut_lo_reg, read_lo_reg;
  logic [7:0]  shut_hi_reg, read_hi_reg;
  logic [15:0] strb_reg, coarse_reg, vd_per_reg, vd_cnt_reg;
  logic        gpi_reg;
  logic [31:0] rdata_reg;

  ////////////////////////////////////////////////////////////////
  wire [23:0] shut_full = {shut_hi_reg, shut_lo_reg};
  wire [23:0] read_full = {read_hi_reg, read_lo_reg};
  // trigger writes are refused while the counts are out of order
  wire cfg_ok = (read_full > shut_full) &&
                (!ctrl_reg[`GRS_CB_BULB] ||
                 shut_full > {8'h00, rst_reg});
  wire wr_ctrl = wr_i && addr_i == `GRS_REG_CTRL;
  wire trig_ok = cfg_ok | ~wdata_i[`GRS_CB_TRIG];
  wire [15:0] status = {8'h00, cfg_ok, lnk.standby, lnk.busy,
                        lnk.strobe, lnk.shutter, lnk.line_valid_flag,
                        lnk.frame_valid_flag, gpi_reg};
  wire [31:0] rd_mux =
    addr_i == `GRS_REG_CTRL     ? {16'h0000, ctrl_reg}    :
    addr_i == `GRS_REG_RST_END  ? {16'h0000, rst_reg}     :
    addr_i == `GRS_REG_SHUT_LO  ? {16'h0000, shut_lo_reg} :
    addr_i == `GRS_REG_SHUT_HI  ? {24'h00_0000, shut_hi_reg} :
    addr_i == `GRS_REG_READ_LO  ? {16'h0000, read_lo_reg} :
    addr_i == `GRS_REG_READ_HI  ? {24'h00_0000, read_hi_reg} :
    addr_i == `GRS_REG_STRB_LEN ? {16'h0000, strb_reg}    :
    addr_i == `GRS_REG_COARSE   ? {16'h0000, coarse_reg}  :
    addr_i == `GRS_REG_VD_PER   ? {16'h0000, vd_per_reg}  :
    addr_i == `GRS_REG_GPI      ? {31'h0000_0000, gpi_reg} :
    addr_i == `GRS_REG_STATUS   ? {16'h0000, status}      :
    32'h0000_0000;

  ////////////////////////////////////////////////////////////////
  always_ff @(posedge mclk_i) begin
    if (reset_i) begin
      ctrl_reg    <= 16'h0000;
      rst_reg     <= 16'h0000;
      shut_lo_reg <= 16'h0000;
      shut_hi_reg <= 8'h00;
      read_lo_reg <= 16'h0000;
      read_hi_reg <= 8'h00;
      strb_reg    <= 16'h0000;
      coarse_reg  <= 16'h0000;
      vd_per_reg  <= 16'h0000;
      gpi_reg     <= 1'b0;
    end else if (wr_i) begin
      if (wr_ctrl && trig_ok)
        ctrl_reg <= {6'h00, wdata_i[9:0]};
      if (addr_i == `GRS_REG_RST_END)
        rst_reg <= wdata_i[15:0];
      if (addr_i == `GRS_REG_SHUT_LO)
        shut_lo_reg <= wdata_i[15:0];
      if (addr_i == `GRS_REG_SHUT_HI)
        shut_hi_reg <= wdata_i[7:0];
      if (addr_i == `GRS_REG_READ_LO)
        read_lo_reg <= wdata_i[15:0];
      if (addr_i == `GRS_REG_READ_HI)
        read_hi_reg <= wdata_i[7:0];
      if (addr_i == `GRS_REG_STRB_LEN)
        strb_reg <= wdata_i[15:0];
      if (addr_i == `GRS_REG_COARSE)
        coarse_reg <= wdata_i[15:0];
      if (addr_i == `GRS_REG_VD_PER)
        vd_per_reg <= wdata_i[15:0];
      if (addr_i == `GRS_REG_GPI)
        gpi_reg <= wdata_i[0];
    end
  end

  always_ff @(posedge mclk_i) begin
    if (reset_i)
      rdata_reg <= 32'h0000_0000;
    else
      rdata_reg <= rd_i ? rd_mux : 32'h0000_0000;
  end

  // free-running sync source; period zero holds it low
  always_ff @(posedge mclk_i) begin
    if (reset_i || vd_per_reg == 16'h0000 ||
        vd_cnt_reg + 16'h0001 >= vd_per_reg)
      vd_cnt_reg <= 16'h0000;
    else
      vd_cnt_reg <= vd_cnt_reg + 16'h0001;
  end

  ////////////////////////////////////////////////////////////////
  assign rdata_o = rdata_reg;
  assign lnk.general_input_pin = gpi_reg;
  assign lnk.vertical_sync_in  = vd_per_reg != 16'h0000 &&
                                 vd_cnt_reg < `GRS_VD_HIGH;
  assign lnk.cfg.stream      = ctrl_reg[`GRS_CB_STREAM];
  assign lnk.cfg.sw_trig     = ctrl_reg[`GRS_CB_TRIG];
  assign lnk.cfg.bulb        = ctrl_reg[`GRS_CB_BULB];
  assign lnk.cfg.strobe_en   = ctrl_reg[`GRS_CB_STROBE];
  assign lnk.cfg.gpi_trig_en = ctrl_reg[`GRS_CB_GPI_TRIG];
  assign lnk.cfg.per_frame_sync_enable =
    ctrl_reg[`GRS_CB_PER_FRAME];
  assign lnk.cfg.sync_wait_timeout_enable = ctrl_reg[`GRS_CB_TMO];
  assign lnk.cfg.sync_triggered_global_enable =
    ctrl_reg[`GRS_CB_SYNC_GLOB];
  assign lnk.cfg.prescale   = ctrl_reg[`GRS_CB_SCALE_LO +: 2];
  assign lnk.cfg.rst_end    = rst_reg;
  assign lnk.cfg.shut_start = shut_full;
  assign lnk.cfg.read_start = read_full;
  assign lnk.cfg.strobe_len = strb_reg;
  assign lnk.cfg.coarse_exp = coarse_reg;
endmodule

// File: rtl/grs_if.sv
interface grs_if;
  grs_pkg::grs_cfg_s cfg;
  logic              general_input_pin;
  logic              vertical_sync_in;
  logic              frame_valid_flag;
  logic              line_valid_flag;
  logic [15:0]       pix_data;
  logic              shutter;
  logic              strobe;
  logic              busy;
  logic              standby;

  modport dev (
    input  cfg, general_input_pin, vertical_sync_in,
    output frame_valid_flag, line_valid_flag, pix_data,
    output shutter, strobe, busy, standby
  );
  modport hst (
    output cfg, general_input_pin, vertical_sync_in,
    input  frame_valid_flag, line_valid_flag, pix_data,
    input  shutter, strobe, busy, standby
  );
endinterface

// File: rtl/grs_params.svh
`ifndef GRS_PARAMS_SVH
`define GRS_PARAMS_SVH

// rolling timing, kept small; clocks and lines
`define GRS_LINE_LAST    12'h03f
`define GRS_ACT_COLS     12'h030
`define GRS_EMB_ROWS     12'h002
`define GRS_OUT_LAST     12'h009
`define GRS_OUT_ROWS     12'h00a
`define GRS_FRAME_LAST   12'h00d
`define GRS_ROWEND_LAST  3'h5
`define GRS_RESUME_BASE  17'h0_000d
`define GRS_INTEG_LINES  17'h0_000a
`define GRS_SHUT_LINES   17'h0_0002
`define GRS_STROBE_DLY   16'h0010
`define GRS_SYNC_TMO     12'hc00
// prescale terminal counts, clocks per count minus one
`define GRS_SCALE0       11'h1ff
`define GRS_SCALE1       11'h7ff
`define GRS_SCALE2       11'h07f
`define GRS_SCALE3       11'h01f
// host register indices
`define GRS_REG_CTRL     4'h0
`define GRS_REG_RST_END  4'h1
`define GRS_REG_SHUT_LO  4'h2
`define GRS_REG_SHUT_HI  4'h3
`define GRS_REG_READ_LO  4'h4
`define GRS_REG_READ_HI  4'h5
`define GRS_REG_STRB_LEN 4'h6
`define GRS_REG_COARSE   4'h7
`define GRS_REG_VD_PER   4'h8
`define GRS_REG_GPI      4'h9
`define GRS_REG_STATUS   4'ha
// control register bits, then the sync pulse high time
`define GRS_CB_STREAM    0
`define GRS_CB_TRIG      1
`define GRS_CB_BULB      2
`define GRS_CB_STROBE    3
`define GRS_CB_GPI_TRIG  4
`define GRS_CB_PER_FRAME 5
`define GRS_CB_TMO       6
`define GRS_CB_SYNC_GLOB 7
`define GRS_CB_SCALE_LO  8
`define GRS_VD_HIGH      16'h0004
`endif

// File: rtl/grs_pkg.sv
package grs_pkg;
  typedef enum logic [2:0] {
    ST_ROLL   = 3'b000,
    ST_ROWEND = 3'b001,
    ST_FRWAIT = 3'b010,
    ST_VDWAIT = 3'b011,
    ST_RESET  = 3'b100,
    ST_INTEG  = 3'b101,
    ST_TAIL   = 3'b110,
    ST_READ   = 3'b111
  } grs_state_e;

  typedef struct packed {
    logic        stream;
    logic        sw_trig;
    logic        bulb;
    logic        strobe_en;
    logic        gpi_trig_en;
    logic        per_frame_sync_enable;
    logic        sync_wait_timeout_enable;
    logic        sync_triggered_global_enable;
    logic [1:0]  prescale;
    logic [15:0] rst_end;
    logic [23:0] shut_start;
    logic [23:0] read_start;
    logic [15:0] strobe_len;
    logic [15:0] coarse_exp;
  } grs_cfg_s;
endpackage

// File: sim/grs_checker.sv
module grs_checker (
  input wire logic              mclk_i,
  input wire logic              reset_i,
  input wire grs_pkg::grs_cfg_s cfg,
  input wire logic              general_input_pin,
  input wire logic              frame_valid_flag,
  input wire logic              line_valid_flag,
  input wire logic [15:0]       pix_data,
  input wire logic              shutter,
  input wire logic              strobe,
  input wire logic              busy,
  input wire logic              standby
);
  logic [7:0]  fvl_cnt;
  logic [15:0] stb_cnt;
  wire         trig_lvl = cfg.sw_trig |
                          (cfg.gpi_trig_en & general_input_pin);
  wire         slave = cfg.per_frame_sync_enable
                     | cfg.sync_triggered_global_enable;
  // saturates so a long standby cannot wrap into the window
  always_ff @(posedge mclk_i) begin
    if (reset_i || frame_valid_flag) fvl_cnt <= 8'h00;
    else if (fvl_cnt != 8'hff) fvl_cnt <= fvl_cnt + 8'h01;
  end
  always_ff @(posedge mclk_i) begin
    if (reset_i || !strobe) stb_cnt <= 16'h0000;
    else stb_cnt <= stb_cnt + 16'h0001;
  end
  default clocking @(posedge mclk_i); endclocking
  default disable iff (reset_i);
  sequence trunc_s;
    frame_valid_flag [*5] ##[1:2] !frame_valid_flag;
  endsequence
  a_trig_edge: assert property (
    $rose(busy) |-> $past(trig_lvl) && !$past(trig_lvl, 2))
    else $error("sequence started without a fresh trigger edge");
  a_fv_trunc: assert property (
    $fell(line_valid_flag) && busy && !shutter && !slave |-> trunc_s)
    else $error("frame valid not dropped six clocks after line");
  a_shut_seq: assert property (
    shutter |-> busy)
    else $error("shutter asserted outside a sequence");
  a_shut_drop: assert property (
    $fell(shutter) |-> fvl_cnt inside {[124:132]} && busy)
    else $error("shutter not released two lines after readout");
  a_lv_in_fv: assert property (
    line_valid_flag |-> frame_valid_flag)
    else $error("line valid outside frame valid");
  a_pix_idle: assert property (
    !line_valid_flag |-> pix_data == 16'h0000)
    else $error("pixel data not zero outside line valid");
  a_strobe_len: assert property (
    $fell(strobe) |-> stb_cnt == cfg.strobe_len)
    else $error("strobe pulse length wrong");
  a_strobe_seq: assert property (
    strobe |-> busy && !frame_valid_flag)
    else $error("strobe outside integration");
  a_busy_stream: assert property (
    busy |-> !standby)
    else $error("standby entered during a sequence");
  a_stby_quiet: assert property (
    standby [*3] |-> !frame_valid_flag)
    else $error("frame output while in standby");
endmodule

// File: sim/tb.sv
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic        mclk_i = 1'b0;
  logic        reset_i = 1'b1;
  logic [3:0]  addr_i = 4'h0;
  logic [31:0] wdata_i = 32'h0000_0000;
  logic        wr_i = 1'b0;
  logic        rd_i = 1'b0;
  logic [31:0] rdata_o;
  logic [15:0] emb;
  logic        integ;
  logic        resum;
  int          bad_count = 0;
  int          tests_run = 0;
  int          n;
  int          lvc;
  int          rows;
  grs_if lnk ();
  grs_device i_grs_device (.mclk_i(mclk_i), .reset_i(reset_i),
    .lnk(lnk.dev), .integrating_o(integ), .resuming_o(resum));
  grs_host i_grs_host (.mclk_i(mclk_i), .reset_i(reset_i), .lnk(lnk.hst),
    .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i),
    .rdata_o(rdata_o));
  grs_checker i_grs_checker (.mclk_i(mclk_i), .reset_i(reset_i),
    .cfg(lnk.cfg), .general_input_pin(lnk.general_input_pin),
    .frame_valid_flag(lnk.frame_valid_flag),
    .line_valid_flag(lnk.line_valid_flag), .pix_data(lnk.pix_data),
    .shutter(lnk.shutter), .strobe(lnk.strobe), .busy(lnk.busy),
    .standby(lnk.standby));
  always #10 mclk_i = ~mclk_i;
  //////////////////////////////////////////////////////////////////////
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      bad_count++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge mclk_i);
    wr_i <= 1'b1;
    addr_i <= a;
    wdata_i <= d;
    @(posedge mclk_i);
    wr_i <= 1'b0;
  endtask
  task automatic rchk(input logic [3:0] a, input logic [31:0] exp);
    @(posedge mclk_i);
    rd_i <= 1'b1;
    addr_i <= a;
    @(posedge mclk_i);
    rd_i <= 1'b0;
    #1 check(rdata_o, exp);
  endtask
  function automatic logic pick(input int s);
    case (s)
      0: pick = lnk.shutter;
      1: pick = lnk.frame_valid_flag;
      3: pick = integ;
      default: pick = lnk.busy;
    endcase
  endfunction
  // bounded wait; the count doubles as the measured delay
  task automatic wait_on(input int s, input logic v, output int c);
    c = 0;
    while (pick(s) !== v && c < 8000) begin
      @(posedge mclk_i);
      c++;
    end
  endtask
  task automatic readout(output int c, output int r, output logic [15:0] p);
    logic q;
    c = 0;
    r = 0;
    q = 1'b0;
    p = 16'h0000;
    // sample before waiting, else the first line cycle is lost
    while (lnk.frame_valid_flag === 1'b1) begin
      if (lnk.line_valid_flag === 1'b1 && !q) r++;
      if (lnk.line_valid_flag === 1'b1 && c == 0) p = lnk.pix_data;
      if (lnk.line_valid_flag === 1'b1) c++;
      q = lnk.line_valid_flag;
      @(posedge mclk_i);
    end
  endtask
  task automatic finish_test();
    $display("tests_run=%0d bad_count=%0d", tests_run, bad_count);
    if (bad_count == 0 && tests_run > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  //////////////////////////////////////////////////////////////////////
  initial begin
    #1ms;
    bad_count++;
    finish_test();
  end
  initial begin
    repeat (10) @(posedge mclk_i);
    reset_i <= 1'b0;
    rchk(4'ha, 32'h0000_0040);
    wr(4'hb, 32'h0000_ffff);
    rchk(4'hb, 32'h0000_0000);
    wr(4'h0, 32'h0000_0003);
    rchk(4'h0, 32'h0000_0000);
    wr(4'h1, 32'h0000_0002);
    wr(4'h2, 32'h0000_0003);
    wr(4'h3, 32'h0000_0000);
    wr(4'h4, 32'h0000_0005);
    wr(4'h5, 32'h0000_0000);
    wr(4'h6, 32'h0000_0008);
    wr(4'h7, 32'h0000_0005);
    rchk(4'h4, 32'h0000_0005);
    $display("test map done");
    // prescale 32, mid-frame trigger so the frame is cut short
    wr(4'h0, 32'h0000_0309);
    repeat (200) @(posedge mclk_i);
    wr(4'h0, 32'h0000_030b);
    wait_on(0, 1'b1, n);
    wr(4'h7, 32'h0000_0007);
    wait_on(1, 1'b1, n);
    check(n inside {[56:68]}, 1'b1);
    readout(lvc, rows, emb);
    check(lvc, 480);
    check(rows, 10);
    check(emb, 16'h0007);
    wait_on(0, 1'b0, n);
    check(n inside {[120:136]}, 1'b1);
    check(resum, 1'b1);
    check(integ, 1'b0);
    wait_on(3, 1'b1, n);
    check(n inside {[504:520]}, 1'b1);
    wait_on(2, 1'b0, n);
    check(n inside {[632:648]}, 1'b1);
    // trigger bit left high must not start another sequence
    repeat (300) @(posedge mclk_i);
    check(lnk.busy, 1'b0);
    $display("test fixed done");
    wr(4'h0, 32'h0000_0315);
    wr(4'h9, 32'h0000_0001);
    wr(4'h0, 32'h0000_0314);
    wait_on(0, 1'b1, n);
    repeat (300) @(posedge mclk_i);
    check(lnk.frame_valid_flag, 1'b0);
    wr(4'h9, 32'h0000_0000);
    wait_on(1, 1'b1, n);
    check(n inside {[32:100]}, 1'b1);
    readout(lvc, rows, emb);
    check(lvc, 480);
    wait_on(2, 1'b0, n);
    rchk(4'ha, 32'h0000_00c0);
    $display("test bulb done");
    // slave frames: sync period, then timeout release
    wr(4'h8, 32'h0000_0400);
    wr(4'h0, 32'h0000_0321);
    wait_on(1, 1'b1, n);
    wait_on(1, 1'b0, n);
    wait_on(1, 1'b1, n);
    check(n inside {[376:392]}, 1'b1);
    wr(4'h8, 32'h0000_ffff);
    wr(4'h0, 32'h0000_0361);
    wait_on(1, 1'b0, n);
    wait_on(1, 1'b1, n);
    check(n inside {[3300:3360]}, 1'b1);
    $display("test slave done");
    // sync capture, prescale 128: reset on one edge, read on the next
    wr(4'h8, 32'h0000_0400);
    wr(4'h0, 32'h0000_0289);
    wr(4'h0, 32'h0000_028b);
    wait_on(0, 1'b1, n);
    wait_on(1, 1'b1, n);
    check(n inside {[632:648]}, 1'b1);
    readout(lvc, rows, emb);
    check(lvc, 480);
    check(rows, 10);
    check(emb, 16'h0007);
    wait_on(0, 1'b0, n);
    check(n inside {[120:136]}, 1'b1);
    $display("test sync done");
    finish_test();
  end
endmodule
